// ### verilog/crd_pkg.sv
// Constants, field layout and types of the control-register decoder.
// Assumes a 50 MHz clock and 24-bit frames delivered whole by the host port.
package crd_pkg;
	// Frame layout, bit positions within the 24-bit word
	localparam int FRM_W = 24;
	localparam int FRM_RW = 23;
	localparam int FRM_DEV_HI = 22;
	localparam int FRM_DEV_LO = 21;
	localparam int FRM_RSEL_HI = 20;
	localparam int FRM_RSEL_LO = 18;
	localparam int FRM_CH_HI = 17;
	localparam int FRM_CH_LO = 16;
	localparam int FRM_CSEL_HI = 15;
	localparam int FRM_CSEL_LO = 13;
	localparam int PAY_W = 13;
	localparam logic [2:0] REGSEL_CTRL = 3'h7;
	localparam logic FRM_WRITE = 1'h0;

	// Control-select codes
	typedef enum logic [2:0] {
		CSEL_SLEW = 3'h0,
		CSEL_MAIN = 3'h1,
		CSEL_CHAN = 3'h2,
		CSEL_BOOST = 3'h3,
		CSEL_SOFT = 3'h4
	} crd_csel_e;

	// Main control payload positions
	localparam int MC_POL = 12;
	localparam int MC_STAT = 11;
	localparam int MC_WDEN = 10;
	localparam int MC_WD_HI = 9;
	localparam int MC_WD_LO = 8;
	localparam int MC_SHORT = 6;
	localparam int MC_ALLOUT = 5;
	localparam int MC_ALLBOOST = 4;

	typedef struct packed {
		logic disabled_output_polarity;
		logic status_on_write_enable;
		logic watchdog_enable_bit;
		logic [1:0] timeout_select;
		logic short_limit_select;
		logic all_outputs_on;
		logic all_boost_on;
	} crd_main_control_s;

	localparam crd_main_control_s MAIN_CONTROL_RST = 8'h00;

	// Watchdog timeouts
	localparam int unsigned CLK_KHZ = 50000;
	localparam int unsigned WD_MS_0 = 5;
	localparam int unsigned WD_MS_1 = 10;
	localparam int unsigned WD_MS_2 = 100;
	localparam int unsigned WD_MS_3 = 200;
	localparam int WDC_W = 24;
	localparam int NCH = 4;
endpackage

// ### verilog/crd_frame_if.sv
// Decoded fields of one received frame, passed decoder to register bank.
// Assumes the decoder drives all fields combinationally from the frame.
interface crd_frame_if;
	import crd_pkg::*;
	logic hit;
	logic [1:0] ch;
	crd_csel_e csel;
	logic [PAY_W-1:0] payload;
	modport dec (output hit, ch, csel, payload);
	modport use_side (input hit, ch, csel, payload);
endinterface

// ### verilog/crd_frame_decode.sv
// Splits a 24-bit frame and qualifies it as a control-register write.
// Assumes the frame and its valid strobe are synchronous to the clock.
module crd_frame_decode
	import crd_pkg::*;
(
	input wire logic i_vld,
	input wire logic [FRM_W-1:0] i_frame,
	input wire logic [1:0] i_dev_addr,
	crd_frame_if.dec o_dec
);
	always_comb begin
		o_dec.hit = i_vld
			&& i_frame[FRM_RW] == FRM_WRITE
			&& i_frame[FRM_RSEL_HI:FRM_RSEL_LO] == REGSEL_CTRL // R01
			&& i_frame[FRM_DEV_HI:FRM_DEV_LO] == i_dev_addr; // R19
		o_dec.ch = i_frame[FRM_CH_HI:FRM_CH_LO]; // R02
		o_dec.csel = crd_csel_e'(i_frame[FRM_CSEL_HI:FRM_CSEL_LO]); // R02
		o_dec.payload = i_frame[PAY_W-1:0]; // R02
	end
endmodule

// ### verilog/crd_main_ctrl.sv
// Control-register decoder and shared main control register.
// Assumes whole frames arrive with a one-cycle valid from the serial port,
// and per-channel enables come from the channel control registers.

// Summary of operation
// R01: Control access only when register-select bits D20:D18 are 111.
// R02: D23 R/W, D22:21 address, D17:16 channel, D15:13 select, D12:0 data.
// R03: Select 000 slew, 001 main, 010 channel, 011 boost, 100 software.
// R04: Slew and channel registers per channel; main, boost, software shared.
// R05: Main fields at D12, D11, D10, D9:D8, D6, D5, D4; rest ignored.
// R06: Polarity bit 0 drives disabled outputs to the pin's level.
// R07: Polarity bit 1 drives disabled outputs to the pin's opposite level.
// R08: Status readback during writes only when its bit is 1; default off.
// R09: Watchdog runs only while its enable bit is 1; resets off.
// R10: Timeout select 00/01/10/11 gives 5, 10, 100, 200 ms.
// R11: Short-circuit limit 16 mA when bit 0, 8 mA when bit 1.
// R12: All-output enable turns on all four channel outputs together.
// R13: Host must not mix all-output enable with per-channel output enables.
// R14: All-boost enable powers all four boost converters together.
// R15: Host disables every output before powering boost converters down; the host model sequences only the all-output and all-boost bits.
// R16: Host must not mix all-boost enable with per-channel boost enables.
// R17: Channel bits 00..11 pick A..D; ignored for shared registers.
// R18: All main control fields clear to zero on reset.
// R19: Frames with a non-matching device address are ignored.
module crd_main_ctrl
	import crd_pkg::*;
#(
	parameter logic [WDC_W-1:0] P_WD_CYC_0 = WDC_W'(WD_MS_0 * CLK_KHZ),
	parameter logic [WDC_W-1:0] P_WD_CYC_1 = WDC_W'(WD_MS_1 * CLK_KHZ),
	parameter logic [WDC_W-1:0] P_WD_CYC_2 = WDC_W'(WD_MS_2 * CLK_KHZ),
	parameter logic [WDC_W-1:0] P_WD_CYC_3 = WDC_W'(WD_MS_3 * CLK_KHZ)
)
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_frame_vld,
	input wire logic [FRM_W-1:0] i_frame,
	input wire logic [1:0] i_dev_addr,
	input wire logic i_pol_pin,
	input wire logic [NCH-1:0] i_channel_output_on,
	input wire logic [NCH-1:0] i_channel_boost_on,
	output logic [PAY_W-1:0] o_payload,
	output logic [NCH-1:0] o_slew_wr,
	output logic [NCH-1:0] o_chan_wr,
	output logic o_boost_wr,
	output logic o_soft_wr,
	output logic [PAY_W-1:0] o_main_control,
	output logic o_disabled_level,
	output logic o_status_on_write,
	output logic o_wd_run,
	output logic [WDC_W-1:0] o_wd_timeout_cyc,
	output logic o_short_limit_8ma,
	output logic [NCH-1:0] o_vout_en,
	output logic [NCH-1:0] o_boost_en
);
	typedef struct packed {
		crd_main_control_s mc;
		logic [PAY_W-1:0] payload;
		logic [NCH-1:0] slew_wr;
		logic [NCH-1:0] chan_wr;
		logic boost_wr;
		logic soft_wr;
		logic dis_level;
		logic [WDC_W-1:0] wd_cyc;
		logic [NCH-1:0] vout_en;
		logic [NCH-1:0] boost_en;
	} crd_state_s;

	localparam crd_state_s STATE_RST = '0;

	function automatic logic [NCH-1:0] crd_onehot(input logic [1:0] ch);
		crd_onehot = NCH'(1) << ch;
	endfunction

	function automatic logic [WDC_W-1:0] crd_timeout(input logic [1:0] sel);
		unique case (sel)
			2'h0: crd_timeout = P_WD_CYC_0;
			2'h1: crd_timeout = P_WD_CYC_1;
			2'h2: crd_timeout = P_WD_CYC_2;
			2'h3: crd_timeout = P_WD_CYC_3;
		endcase
	endfunction

	// Reset released through two flops so release is glitch-free
	logic rst_meta_r;
	logic rstn_r;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta_r <= 1'h0;
			rstn_r <= 1'h0;
		end else begin
			rst_meta_r <= 1'h1;
			rstn_r <= rst_meta_r;
		end
	end

	crd_frame_if dec_if ();

	crd_frame_decode u_dec (
		.i_vld(i_frame_vld),
		.i_frame(i_frame),
		.i_dev_addr(i_dev_addr),
		.o_dec(dec_if.dec)
	);

	crd_state_s st_r;
	crd_state_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.slew_wr = '0;
		st_nxt.chan_wr = '0;
		st_nxt.boost_wr = 1'h0;
		st_nxt.soft_wr = 1'h0;
		if (dec_if.hit) begin
			st_nxt.payload = dec_if.payload;
			unique case (dec_if.csel)
				CSEL_SLEW: st_nxt.slew_wr = crd_onehot(dec_if.ch); // R04
				CSEL_CHAN: st_nxt.chan_wr = crd_onehot(dec_if.ch); // R17
				CSEL_BOOST: st_nxt.boost_wr = 1'h1; // R03
				CSEL_SOFT: st_nxt.soft_wr = 1'h1; // R03
				CSEL_MAIN: begin
					// Channel bits and D7, D3:D0 are dropped here
					st_nxt.mc.disabled_output_polarity =
						dec_if.payload[MC_POL]; // R05
					st_nxt.mc.status_on_write_enable =
						dec_if.payload[MC_STAT];
					st_nxt.mc.watchdog_enable_bit = dec_if.payload[MC_WDEN];
					st_nxt.mc.timeout_select =
						dec_if.payload[MC_WD_HI:MC_WD_LO];
					st_nxt.mc.short_limit_select = dec_if.payload[MC_SHORT];
					st_nxt.mc.all_outputs_on = dec_if.payload[MC_ALLOUT];
					st_nxt.mc.all_boost_on = dec_if.payload[MC_ALLBOOST];
				end
				// Undefined select codes write nothing
				default: st_nxt.payload = st_r.payload;
			endcase
		end
		st_nxt.dis_level =
			i_pol_pin ^ st_r.mc.disabled_output_polarity; // R06 R07
		st_nxt.wd_cyc = crd_timeout(st_r.mc.timeout_select); // R10
		// Gang enable ORs with channel enables; mixing them is host misuse
		st_nxt.vout_en = i_channel_output_on
			| {NCH{st_r.mc.all_outputs_on}}; // R12 R13
		st_nxt.boost_en = i_channel_boost_on
			| {NCH{st_r.mc.all_boost_on}}; // R14 R16
	end

	always_ff @(posedge i_clk or negedge rstn_r) begin
		if (!rstn_r) begin
			st_r <= STATE_RST; // R18
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_payload = st_r.payload;
	assign o_slew_wr = st_r.slew_wr;
	assign o_chan_wr = st_r.chan_wr;
	assign o_boost_wr = st_r.boost_wr;
	assign o_soft_wr = st_r.soft_wr;
	assign o_main_control = {st_r.mc.disabled_output_polarity,
		st_r.mc.status_on_write_enable, st_r.mc.watchdog_enable_bit,
		st_r.mc.timeout_select, 1'h0, st_r.mc.short_limit_select,
		st_r.mc.all_outputs_on, st_r.mc.all_boost_on, 4'h0};
	assign o_disabled_level = st_r.dis_level;
	assign o_status_on_write = st_r.mc.status_on_write_enable; // R08
	assign o_wd_run = st_r.mc.watchdog_enable_bit; // R09
	assign o_wd_timeout_cyc = st_r.wd_cyc;
	assign o_short_limit_8ma = st_r.mc.short_limit_select; // R11
	assign o_vout_en = st_r.vout_en;
	assign o_boost_en = st_r.boost_en;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!rstn_r);

	logic main_hit;
	logic addr_ok;
	assign main_hit = dec_if.hit && dec_if.csel == CSEL_MAIN;
	assign addr_ok = i_frame[FRM_DEV_HI:FRM_DEV_LO] == i_dev_addr;

	a_main_load_fields: assert property ( // R05
		main_hit |=> o_main_control[PAY_W-1:MC_WD_LO]
			== $past(i_frame[PAY_W-1:MC_WD_LO])
			&& o_main_control[MC_SHORT:MC_ALLBOOST]
			== $past(i_frame[MC_SHORT:MC_ALLBOOST]))
		else $error("main control not loaded from frame");
	a_addr_mismatch_hold: assert property ( // R19
		i_frame_vld && !addr_ok |=> $stable(o_main_control)
			&& o_slew_wr == '0 && o_chan_wr == '0)
		else $error("frame for other address acted on");
	a_regsel_gate_strobe: assert property ( // R01
		i_frame_vld && i_frame[FRM_RSEL_HI:FRM_RSEL_LO] != REGSEL_CTRL
			|=> o_slew_wr == '0 && !o_boost_wr && !o_soft_wr
			&& $stable(o_main_control))
		else $error("non-control frame raised a strobe");
	a_chan_strobe_sel: assert property ( // R17
		dec_if.hit && dec_if.csel == CSEL_CHAN
			|=> o_chan_wr == NCH'(1) << $past(i_frame[FRM_CH_HI:FRM_CH_LO])
			&& o_slew_wr == '0)
		else $error("wrong channel strobe");
	a_boost_soft_sel: assert property ( // R03
		o_boost_wr || o_soft_wr |-> $past(dec_if.hit)
			&& $past(i_frame[FRM_CSEL_HI]) == o_soft_wr)
		else $error("shared strobe without its select code");
	a_disabled_level_pol: assert property ( // R07
		rstn_r |=> o_disabled_level == ($past(i_pol_pin)
			^ $past(o_main_control[MC_POL])))
		else $error("disabled output level wrong");
	a_gang_output_en: assert property ( // R12
		o_main_control[MC_ALLOUT] ##1 o_main_control[MC_ALLOUT]
			|-> o_vout_en == 4'hF)
		else $error("all-output enable did not reach every channel");
	a_gang_boost_en: assert property ( // R14
		o_main_control[MC_ALLBOOST] ##1 o_main_control[MC_ALLBOOST]
			|-> o_boost_en == 4'hF)
		else $error("all-boost enable did not reach every channel");
	a_wd_timeout_map: assert property ( // R10
		// Timeout count lags release by one cycle, so reset edge is skipped
		(rstn_r && $stable(o_main_control)) [*2] |-> o_wd_timeout_cyc ==
			(o_main_control[MC_WD_HI:MC_WD_LO] == 2'h3 ? P_WD_CYC_3 :
			o_main_control[MC_WD_HI:MC_WD_LO] == 2'h2 ? P_WD_CYC_2 :
			o_main_control[MC_WD_HI:MC_WD_LO] == 2'h1 ? P_WD_CYC_1 :
			P_WD_CYC_0))
		else $error("watchdog timeout count mismatch");
	a_wd_stat_follow: assert property ( // R09
		main_hit |=> o_wd_run == $past(i_frame[MC_WDEN])
			&& o_status_on_write == $past(i_frame[MC_STAT])
			&& o_short_limit_8ma == $past(i_frame[MC_SHORT]))
		else $error("control level out of step with register");
	a_reset_defaults: assert property ( // R18
		$rose(rstn_r) |-> o_main_control == '0)
		else $error("main control not cleared by reset");

	c_main_write: cover property (main_hit);
	c_gang_outputs: cover property (o_vout_en == 4'hF);
	c_slew_ch_d: cover property (o_slew_wr == 4'h8);
	c_wd_longest: cover property (o_wd_run && o_wd_timeout_cyc == P_WD_CYC_3);
endmodule

// ### verification/crd_host_model.sv
// Host side of the frame port: sends whole frames with a one-cycle valid.
// Assumes the bench calls send from just after a rising clock edge.
module crd_host_model
	import crd_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [1:0] i_dev_addr,
	output logic o_vld,
	output logic [FRM_W-1:0] o_frame,
	output logic o_gang_out,
	output logic o_gang_boost
);
	timeunit 1ns;
	timeprecision 1ps;
	// Gang state starts cleared, so no race with the first reset edge
	initial begin
		o_vld = 1'b0;
		o_frame = '0;
		forever begin
			o_gang_out = 1'b0;
			o_gang_boost = 1'b0;
			@(negedge i_rstn);
		end
	end
	task automatic send(input logic [FRM_W-1:0] f,
		output logic [FRM_W-1:0] g);
		g = f;
		// Channel bits are ignored for main control writes
		if (g[23:18] == {FRM_WRITE, i_dev_addr, REGSEL_CTRL}
			&& g[15:13] == CSEL_MAIN) begin
			// Outputs go off in one frame, converters in a later one
			if (o_gang_boost && !g[MC_ALLBOOST]) begin
				g[MC_ALLBOOST] = o_gang_out;
				g[MC_ALLOUT] = 1'b0;
			end
			o_gang_out = g[MC_ALLOUT];
			o_gang_boost = g[MC_ALLBOOST];
		end
		o_vld = 1'b1;
		o_frame = g;
		@(posedge i_clk);
		#1;
		o_vld = 1'b0;
		// Idle line never repeats the last frame
		o_frame = ~g;
	endtask
endmodule

// ### verification/control_register_decode_main_ctrl_tb_top.sv
// Random control frames against a queue-free integer model of the bank.
// Assumes reduced watchdog counts of 10, 20, 30 and 40 cycles.
module control_register_decode_main_ctrl_tb_top
	import crd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CYC [4] = '{10, 20, 30, 40};
	logic i_clk, i_rstn, pol, hv, go, gb;
	logic [1:0] dev, ch;
	logic [3:0] cho, chb, sw, cw;
	logic [2:0] rs, cs;
	logic [12:0] pay, m_main, m_pay, mc, op;
	logic [FRM_W-1:0] f, g, hf;
	logic [WDC_W-1:0] wc;
	logic bw, fw, dl, st, wr, sl, hit;
	logic [3:0] ve, be;
	int miscompares, check_count;
	crd_host_model host (.i_clk(i_clk), .i_rstn(i_rstn), .i_dev_addr(dev),
		.o_vld(hv), .o_frame(hf), .o_gang_out(go), .o_gang_boost(gb));
	crd_main_ctrl #(.P_WD_CYC_0(24'h00000A), .P_WD_CYC_1(24'h000014),
		.P_WD_CYC_2(24'h00001E), .P_WD_CYC_3(24'h000028)) dut (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_frame_vld(hv), .i_frame(hf),
		.i_dev_addr(dev), .i_pol_pin(pol), .i_channel_output_on(cho),
		.i_channel_boost_on(chb), .o_payload(op), .o_slew_wr(sw),
		.o_chan_wr(cw), .o_boost_wr(bw), .o_soft_wr(fw), .o_main_control(mc),
		.o_disabled_level(dl), .o_status_on_write(st), .o_wd_run(wr),
		.o_wd_timeout_cyc(wc), .o_short_limit_8ma(sl), .o_vout_en(ve),
		.o_boost_en(be));
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	task automatic check(input string nm, input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic give_verdict();
		if (miscompares == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check_regs();
		check("level", dl, pol ^ m_main[MC_POL]);
		check("status", st, m_main[MC_STAT]);
		check("wd_run", wr, m_main[MC_WDEN]);
		check("wd_cyc", wc, CYC[m_main[9:8]]);
		check("short", sl, m_main[MC_SHORT]);
		check("vout", ve, cho | {4{m_main[MC_ALLOUT]}});
		check("boost", be, chb | {4{m_main[MC_ALLBOOST]}});
		check("main", mc, m_main);
		check("payload", op, m_pay);
		check("idle", {sw, cw, bw, fw}, 0);
	endtask
	task automatic do_reset();
		i_rstn = 1'b0;
		dev = 2'($urandom);
		cho = 4'h0;
		chb = 4'h0;
		m_main = '0;
		m_pay = '0;
		repeat (3) @(posedge i_clk);
		#1 i_rstn = 1'b1;
		repeat (5) @(posedge i_clk);
		#1 check_regs();
	endtask
	initial begin
		i_rstn = 1'b0;
		pol = 1'b0;
		void'($urandom(32));
		for (int p = 0; p < 2; p++) begin
			// Second pass restarts from a mid-run reset
			do_reset();
			for (int n = 0; n < 150; n++) begin
				rs = ($urandom % 4 == 0) ? 3'($urandom) : REGSEL_CTRL;
				cs = ($urandom % 3 == 0) ? CSEL_MAIN : 3'($urandom);
				ch = 2'($urandom);
				pay = 13'($urandom);
				f = {1'($urandom % 4 == 0), ($urandom % 4 == 0) ? ~dev : dev,
					rs, ch, cs, pay};
				host.send(f, g);
				hit = g[23:18] == {FRM_WRITE, dev, REGSEL_CTRL};
				// Host may have reshaped a main payload for sequencing
				if (hit && cs <= CSEL_SOFT)
					m_pay = g[12:0];
				if (hit && cs == CSEL_MAIN)
					m_main = g[12:0] & 13'h1F70;
				check("slew", sw, (hit && cs == 0) ? 4'h1 << ch : 4'h0);
				check("chan", cw, (hit && cs == 2) ? 4'h1 << ch : 4'h0);
				check("bst_wr", bw, hit && cs == 3);
				check("soft_wr", fw, hit && cs == 4);
				check("main_now", mc, m_main);
				pol = 1'($urandom);
				// No mixing of gang and channel enables
				cho = go ? 4'h0 : 4'($urandom);
				chb = gb ? 4'h0 : 4'($urandom);
				@(posedge i_clk);
				#1 check_regs();
			end
		end
		give_verdict();
	end
	initial begin
		repeat (100000) @(posedge i_clk);
		miscompares++;
		give_verdict();
	end
endmodule
